// >>> core/ucd_pkg.sv
// Constants, timing counts and enumerations shared by the charger detection sequencer
package ucd_pkg;

  // ****************************************************************
  // Clock rate
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 200;

  // ****************************************************************
  // Phase timing
  // ****************************************************************
  // Data contact detection gives up after this long
  localparam int unsigned DCD_TIMEOUT_MS  = 600;
  localparam int unsigned DCD_TIMEOUT_CYC = DCD_TIMEOUT_MS * CLK_MHZ * 1000;
  // Contact must stand this long before it counts
  localparam int unsigned DCD_DBNC_MS     = 10;
  localparam int unsigned DCD_DBNC_CYC    = DCD_DBNC_MS * CLK_MHZ * 1000;
  // Settling time of each comparator phase
  localparam int unsigned SETTLE_MS       = 40;
  localparam int unsigned SETTLE_CYC      = SETTLE_MS * CLK_MHZ * 1000;
  localparam int unsigned PHASE_W         = 27;

  // ****************************************************************
  // Dead-battery timer
  // ****************************************************************
  localparam longint unsigned DBT_TIME_MIN = 30;
  localparam longint unsigned DBT_MAX_MIN  = 45;
  localparam longint unsigned DBT_CYC      = DBT_TIME_MIN * 64'd60 * CLK_MHZ * 64'd1000000;
  localparam longint unsigned DBT_MAX_CYC  = DBT_MAX_MIN * 64'd60 * CLK_MHZ * 64'd1000000;
  localparam int unsigned     DBT_W        = 39;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DCD     = 3'h1,
    ST_PRI     = 3'h2,
    ST_SEC     = 3'h3,
    ST_PROP    = 3'h4,
    ST_DONE    = 3'h5,
    ST_EXPIRED = 3'h6
  } ucd_state_t;

  // ****************************************************************
  // Accessory classes
  // ****************************************************************
  typedef enum logic [2:0] {
    CLS_NONE   = 3'h0,
    CLS_SDP    = 3'h1,
    CLS_CDP    = 3'h2,
    CLS_DCP    = 3'h3,
    CLS_PROP_A = 3'h4,
    CLS_PROP_B = 3'h5,
    CLS_PULLUP = 3'h6,
    CLS_OPEN   = 3'h7
  } ucd_class_t;

endpackage : ucd_pkg

// >>> core/ucd_timer.sv
// Limit timer that holds at its limit and clears whenever it is not told to run
`timescale 1ns/1ps
module ucd_timer #(
  parameter int unsigned     WIDTH = ucd_pkg::DBT_W,
  parameter longint unsigned LIMIT = ucd_pkg::DBT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic run,
  output logic      expired
);

  localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 64'd1);

  if (LIMIT < 64'd1 || LIMIT > (64'd1 << WIDTH)) begin : g_bad_limit
    $error("ucd_timer: LIMIT does not fit WIDTH");
  end

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             expired_q;
  logic             expired_d;

  always_comb begin
    count_d   = count_q;
    expired_d = expired_q;
    if (!run) begin
      count_d   = '0;
      expired_d = 1'b0;
    end else if (count_q == LAST) begin
      expired_d = 1'b1;
    end else begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q;

endmodule : ucd_timer

// >>> core/ucd_seq.sv
// Charger detection sequencer: supply check, contact detection, classification, switch and charge control
`timescale 1ns/1ps
module ucd_seq #(
  parameter int unsigned     DCD_TIMEOUT_CYC = ucd_pkg::DCD_TIMEOUT_CYC,
  parameter int unsigned     DCD_DBNC_CYC    = ucd_pkg::DCD_DBNC_CYC,
  parameter int unsigned     SETTLE_CYC      = ucd_pkg::SETTLE_CYC,
  parameter int unsigned     PHASE_W         = ucd_pkg::PHASE_W,
  parameter longint unsigned DBT_CYC         = ucd_pkg::DBT_CYC,
  parameter int unsigned     DBT_W           = ucd_pkg::DBT_W
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic         vbus_valid_in,
  input  wire logic         battery_ok_in,
  input  wire logic         contact_in,
  input  wire logic         dminus_above_vdat_in,
  input  wire logic         dplus_above_vdat_in,
  input  wire logic         dp_win28_in,
  input  wire logic         dm_win28_in,
  input  wire logic         dp_win31_in,
  input  wire logic         dm_win31_in,
  input  wire logic         dp_at_vbus_in,
  input  wire logic         dm_at_vbus_in,
  output logic              dcd_src_en,
  output logic              dplus_src_en,
  output logic              dminus_source_voltage_en,
  output logic              data_switch_close,
  output logic              switch_state_out_o,
  output logic              switch_state_out_oe,
  output logic              charge_permit_n_o,
  output logic              charge_permit_n_oe,
  output logic              charger_found_out,
  output logic [2:0]        detected_class,
  output logic              dead_battery_expired
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (DCD_TIMEOUT_CYC < 1 || DCD_TIMEOUT_CYC > (1 << PHASE_W)) begin : g_bad_dcd
    $error("ucd_seq: DCD_TIMEOUT_CYC does not fit PHASE_W");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > (1 << PHASE_W)) begin : g_bad_settle
    $error("ucd_seq: SETTLE_CYC does not fit PHASE_W");
  end
  if (DCD_DBNC_CYC < 1 || DCD_DBNC_CYC > (1 << PHASE_W)) begin : g_bad_dbnc
    $error("ucd_seq: DCD_DBNC_CYC does not fit PHASE_W");
  end
  if (DBT_CYC > ucd_pkg::DBT_MAX_CYC) begin : g_bad_dbt
    $error("ucd_seq: DBT_CYC beyond the longest allowed time");
  end

  localparam logic [PHASE_W-1:0] DCD_LAST    = PHASE_W'(DCD_TIMEOUT_CYC - 1);
  localparam logic [PHASE_W-1:0] DBNC_LAST   = PHASE_W'(DCD_DBNC_CYC - 1);
  localparam logic [PHASE_W-1:0] SETTLE_LAST = PHASE_W'(SETTLE_CYC - 1);

  // ****************************************************************
  // Class decoding
  // ****************************************************************
  function automatic logic is_charger(input ucd_pkg::ucd_class_t cls);
    logic hit;
    hit = 1'b0;
    case (cls)
      ucd_pkg::CLS_CDP,
      ucd_pkg::CLS_DCP,
      ucd_pkg::CLS_PROP_A,
      ucd_pkg::CLS_PROP_B: hit = 1'b1;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction : is_charger

  function automatic logic is_data_port(input ucd_pkg::ucd_class_t cls);
    return (cls == ucd_pkg::CLS_SDP) || (cls == ucd_pkg::CLS_CDP);
  endfunction : is_data_port

  // ****************************************************************
  // State
  // ****************************************************************
  ucd_pkg::ucd_state_t state_q;
  ucd_pkg::ucd_state_t state_d;
  ucd_pkg::ucd_class_t cls_q;
  ucd_pkg::ucd_class_t cls_d;
  logic [PHASE_W-1:0]  phase_cnt_q;
  logic [PHASE_W-1:0]  phase_cnt_d;
  logic [PHASE_W-1:0]  dbnc_cnt_q;
  logic [PHASE_W-1:0]  dbnc_cnt_d;
  logic                dcd_src_q;
  logic                dcd_src_d;
  logic                dplus_src_q;
  logic                dplus_src_d;
  logic                dminus_src_q;
  logic                dminus_src_d;
  logic                sw_close_q;
  logic                sw_close_d;
  logic                permit_oe_q;
  logic                permit_oe_d;
  logic                found_q;
  logic                found_d;
  logic                expired_q;
  logic                expired_d;
  logic                dbt_run;
  logic                dbt_expired;

  // ****************************************************************
  // Dead-battery timer
  // ****************************************************************
  // Battery going good before expiry clears the count: low must be continuous
  // timer run condition
  assign dbt_run = (state_q == ucd_pkg::ST_DONE) && (cls_q != ucd_pkg::CLS_NONE) && !battery_ok_in;

  ucd_timer #(
    .WIDTH (DBT_W),
    .LIMIT (DBT_CYC)
  ) u_dbt_timer (
    .clk_sys (clk_sys),
    .srst    (srst),
    .run     (dbt_run),
    .expired (dbt_expired)
  );

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  always_comb begin
    state_d     = state_q;
    cls_d       = cls_q;
    phase_cnt_d = phase_cnt_q + PHASE_W'(1);
    dbnc_cnt_d  = '0;
    case (state_q)
      ucd_pkg::ST_IDLE: begin
        phase_cnt_d = '0;
        cls_d       = ucd_pkg::CLS_NONE;
        if (vbus_valid_in) begin
          state_d = ucd_pkg::ST_DCD;
        end
      end
      ucd_pkg::ST_DCD: begin
        // Saturating debounce so a long contact never wraps
        if (contact_in) begin
          dbnc_cnt_d = (dbnc_cnt_q == DBNC_LAST) ? dbnc_cnt_q : dbnc_cnt_q + PHASE_W'(1);
        end
        // contact goes primary, timeout goes proprietary
        if (contact_in && dbnc_cnt_q == DBNC_LAST) begin
          state_d     = ucd_pkg::ST_PRI;
          phase_cnt_d = '0;
        end else if (phase_cnt_q == DCD_LAST) begin
          state_d     = ucd_pkg::ST_PROP;
          phase_cnt_d = '0;
        end
      end
      ucd_pkg::ST_PRI: begin
        // primary split, standard or charging port
        if (phase_cnt_q == SETTLE_LAST) begin
          phase_cnt_d = '0;
          if (dminus_above_vdat_in) begin
            state_d = ucd_pkg::ST_SEC;
          end else begin
            cls_d   = ucd_pkg::CLS_SDP;
            state_d = ucd_pkg::ST_DONE;
          end
        end
      end
      ucd_pkg::ST_SEC: begin
        // secondary split, dedicated or charging downstream
        if (phase_cnt_q == SETTLE_LAST) begin
          phase_cnt_d = '0;
          cls_d       = dplus_above_vdat_in ? ucd_pkg::CLS_DCP : ucd_pkg::CLS_CDP;
          state_d     = ucd_pkg::ST_DONE;
        end
      end
      ucd_pkg::ST_PROP: begin
        if (phase_cnt_q == SETTLE_LAST) begin
          phase_cnt_d = '0;
          state_d     = ucd_pkg::ST_DONE;
          // Narrow window tested first: its range lies inside the wider one
          if (dp_win28_in && dm_win28_in) begin
            cls_d = ucd_pkg::CLS_PROP_A;
          end else if (dp_win31_in && dm_win31_in) begin
            cls_d = ucd_pkg::CLS_PROP_B;
          end else if (dp_at_vbus_in && dm_at_vbus_in) begin
            cls_d = ucd_pkg::CLS_PULLUP;
          end else begin
            cls_d = ucd_pkg::CLS_OPEN;
          end
        end
      end
      ucd_pkg::ST_DONE: begin
        phase_cnt_d = '0;
        if (dbt_expired) begin
          state_d = ucd_pkg::ST_EXPIRED;
        end
      end
      ucd_pkg::ST_EXPIRED: begin
        phase_cnt_d = '0;
        if (battery_ok_in) begin
          state_d = ucd_pkg::ST_DCD;
          cls_d   = ucd_pkg::CLS_NONE;
        end
      end
      default: begin
        state_d     = ucd_pkg::ST_IDLE;
        cls_d       = ucd_pkg::CLS_NONE;
        phase_cnt_d = '0;
      end
    endcase
    if (!vbus_valid_in) begin
      state_d     = ucd_pkg::ST_IDLE;
      cls_d       = ucd_pkg::CLS_NONE;
      phase_cnt_d = '0;
      dbnc_cnt_d  = '0;
    end
  end

  // ****************************************************************
  // Output next values
  // ****************************************************************
  // Derived from the next state so pins move with the state, not a cycle after
  always_comb begin
    dcd_src_d    = (state_d == ucd_pkg::ST_DCD);
    dplus_src_d  = (state_d == ucd_pkg::ST_PRI);
    dminus_src_d = (state_d == ucd_pkg::ST_SEC);
    // only data ports with good battery connect
    sw_close_d   = (state_d == ucd_pkg::ST_DONE) && is_data_port(cls_d) && battery_ok_in;
    found_d      = (state_d == ucd_pkg::ST_DONE) && is_charger(cls_d);
    // permit while supply valid and not expired
    permit_oe_d  = vbus_valid_in && (state_d != ucd_pkg::ST_EXPIRED);
    expired_d    = (state_d == ucd_pkg::ST_EXPIRED);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q      <= ucd_pkg::ST_IDLE;
      cls_q        <= ucd_pkg::CLS_NONE;
      phase_cnt_q  <= '0;
      dbnc_cnt_q   <= '0;
      dcd_src_q    <= 1'b0;
      dplus_src_q  <= 1'b0;
      dminus_src_q <= 1'b0;
      sw_close_q   <= 1'b0;
      permit_oe_q  <= 1'b0;
      found_q      <= 1'b0;
      expired_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      cls_q        <= cls_d;
      phase_cnt_q  <= phase_cnt_d;
      dbnc_cnt_q   <= dbnc_cnt_d;
      dcd_src_q    <= dcd_src_d;
      dplus_src_q  <= dplus_src_d;
      dminus_src_q <= dminus_src_d;
      sw_close_q   <= sw_close_d;
      permit_oe_q  <= permit_oe_d;
      found_q      <= found_d;
      expired_q    <= expired_d;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  // Open-drain pins only ever pull low; the level bits are held at zero
  assign dcd_src_en               = dcd_src_q;
  assign dplus_src_en             = dplus_src_q;
  assign dminus_source_voltage_en = dminus_src_q;
  assign data_switch_close        = sw_close_q;
  assign switch_state_out_oe      = sw_close_q;
  assign switch_state_out_o       = 1'b0;
  // charge permit pulls low to allow
  assign charge_permit_n_oe       = permit_oe_q;
  assign charge_permit_n_o        = 1'b0;
  assign charger_found_out        = found_q;
  assign detected_class           = cls_q;
  assign dead_battery_expired     = expired_q;

endmodule : ucd_seq

// >>> verif/ucd_far_end.sv
// Far-side port model: line signatures of every attachable source class
`timescale 1ns/1ps
module ucd_far_end (
  input  wire logic [2:0] kind,
  input  wire logic       dcd_src_en,
  input  wire logic       dplus_src_en,
  input  wire logic       dminus_source_voltage_en,
  output logic            contact_in,
  output logic            dminus_above_vdat_in,
  output logic            dplus_above_vdat_in,
  output logic            dp_win28_in,
  output logic            dm_win28_in,
  output logic            dp_win31_in,
  output logic            dm_win31_in,
  output logic            dp_at_vbus_in,
  output logic            dm_at_vbus_in
);
  assign contact_in = dcd_src_en && kind != 3'h0 && kind <= 3'h3;
  assign dminus_above_vdat_in = dplus_src_en && (kind == 3'h2 || kind == 3'h3);
  assign dplus_above_vdat_in = dminus_source_voltage_en && kind == 3'h3;
  // window chargers; lower window sits inside the upper one
  assign {dp_win28_in, dm_win28_in} = {2{kind == 3'h4}};
  assign {dp_win31_in, dm_win31_in} = {2{kind == 3'h4 || kind == 3'h5}};
  assign {dp_at_vbus_in, dm_at_vbus_in} = {2{kind == 3'h6}};
endmodule : ucd_far_end

// >>> verif/ucd_seq_assertions.sv
// Port-level concurrent checks for the charger detection sequencer
`timescale 1ns/1ps
module ucd_seq_assertions #(
  parameter int unsigned     DCD_TIMEOUT_CYC = ucd_pkg::DCD_TIMEOUT_CYC,
  parameter longint unsigned DBT_CYC         = ucd_pkg::DBT_CYC
) (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       vbus_valid_in,
  input wire logic       battery_ok_in,
  input wire logic       contact_in,
  input wire logic       dminus_above_vdat_in,
  input wire logic       dcd_src_en,
  input wire logic       dplus_src_en,
  input wire logic       dminus_source_voltage_en,
  input wire logic       data_switch_close,
  input wire logic       switch_state_out_o,
  input wire logic       switch_state_out_oe,
  input wire logic       charge_permit_n_o,
  input wire logic       charge_permit_n_oe,
  input wire logic       charger_found_out,
  input wire logic [2:0] detected_class,
  input wire logic       dead_battery_expired
);
  longint unsigned dcd_cnt_q;
  longint unsigned low_cnt_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Run lengths of the contact phase and of any detected class seen with a dead battery
  always_ff @(posedge clk_sys) begin
    dcd_cnt_q <= (srst || !dcd_src_en) ? 64'h0 : dcd_cnt_q + 64'h1;
    low_cnt_q <= (srst || battery_ok_in || detected_class == 3'h0 || dead_battery_expired) ? 64'h0 : low_cnt_q + 64'h1;
  end
  AST_DCD_START: assert property (!vbus_valid_in ##1 vbus_valid_in |=> dcd_src_en)
    else $error("contact phase did not start after supply rise");
  AST_DCD_BOUND: assert property (dcd_cnt_q <= DCD_TIMEOUT_CYC + 1)
    else $error("contact phase outlived its timeout");
  AST_NO_CONTACT_PROP: assert property ($fell(dcd_src_en) && $past(vbus_valid_in) && !$past(contact_in)
    |-> !dplus_src_en)
    else $error("primary phase entered without contact");
  AST_PRI_SPLIT: assert property ($fell(dplus_src_en) && $past(vbus_valid_in)
    |-> dminus_source_voltage_en == $past(dminus_above_vdat_in)
        && (dminus_source_voltage_en || detected_class == 3'h1))
    else $error("primary phase outcome wrong");
  AST_SWITCH_CLOSE: assert property (data_switch_close
    |-> (detected_class == 3'h1 || detected_class == 3'h2) && $past(battery_ok_in))
    else $error("data switch closed for wrong class or dead battery");
  AST_SWITCH_PIN: assert property (switch_state_out_oe == data_switch_close && !switch_state_out_o)
    else $error("switch-state pin disagrees with switch");
  AST_FOUND: assert property (charger_found_out
    == (detected_class >= 3'h2 && detected_class <= 3'h5 && !dead_battery_expired))
    else $error("charger-found level wrong for class");
  AST_PERMIT: assert property (charge_permit_n_oe
    |-> $past(vbus_valid_in) && !dead_battery_expired && !charge_permit_n_o)
    else $error("charge permit pulled low when forbidden");
  AST_SUPPLY_LOSS: assert property (!vbus_valid_in |=> !data_switch_close && !charger_found_out
    && !charge_permit_n_oe && !switch_state_out_oe && detected_class == 3'h0)
    else $error("outputs not released after supply loss");
  AST_DBT_RUNS: assert property (low_cnt_q <= DBT_CYC + 3)
    else $error("dead-battery timer did not run out");
  AST_DBT_EXPIRE: assert property ($rose(dead_battery_expired)
    |-> low_cnt_q + 2 >= DBT_CYC && low_cnt_q <= DBT_CYC * 3 / 2)
    else $error("dead-battery expiry at wrong time");
  AST_RESTART: assert property (dead_battery_expired && battery_ok_in && vbus_valid_in
    |=> dcd_src_en && !dead_battery_expired)
    else $error("no restart after battery good");
  cover property ($rose(dead_battery_expired));
  cover property ($rose(data_switch_close));
  cover property (detected_class == 3'h4);
endmodule : ucd_seq_assertions

// >>> verif/testbench.sv
// Self-checking bench for the charger detection sequencer
`timescale 1ns/1ps
module testbench;
  localparam int TMO = 1000;
  localparam int DBT = 300;
  logic       clk_sys = 1'b0;
  logic       srst    = 1'b1;
  logic       vbus    = 1'b0;
  logic       bat     = 1'b0;
  logic [2:0] kind    = 3'h0;
  logic       contact, dm_above, dp_above, dp28, dm28, dp31, dm31, dpv, dmv;
  logic       dcd_en, dp_src, dm_src, sw_close, sw_o, sw_oe, perm_o, perm_oe, found, expired;
  logic [2:0] cls;
  logic [6:0] outs;
  int         failures = 0;
  int         checked  = 0;
  int         cycles   = 0;
  int         n;
  assign outs = {found, sw_close, sw_oe, perm_oe, expired, sw_o, perm_o};
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  ucd_seq #(.DCD_TIMEOUT_CYC(200), .DCD_DBNC_CYC(5), .SETTLE_CYC(10), .DBT_CYC(DBT)) i_ucd_seq (
    .clk_sys(clk_sys), .srst(srst), .vbus_valid_in(vbus), .battery_ok_in(bat), .contact_in(contact),
    .dminus_above_vdat_in(dm_above), .dplus_above_vdat_in(dp_above), .dp_win28_in(dp28), .dm_win28_in(dm28),
    .dp_win31_in(dp31), .dm_win31_in(dm31), .dp_at_vbus_in(dpv), .dm_at_vbus_in(dmv), .dcd_src_en(dcd_en),
    .dplus_src_en(dp_src), .dminus_source_voltage_en(dm_src), .data_switch_close(sw_close),
    .switch_state_out_o(sw_o), .switch_state_out_oe(sw_oe), .charge_permit_n_o(perm_o),
    .charge_permit_n_oe(perm_oe), .charger_found_out(found), .detected_class(cls), .dead_battery_expired(expired));
  ucd_far_end i_ucd_far_end (
    .kind(kind), .dcd_src_en(dcd_en), .dplus_src_en(dp_src), .dminus_source_voltage_en(dm_src),
    .contact_in(contact), .dminus_above_vdat_in(dm_above), .dplus_above_vdat_in(dp_above), .dp_win28_in(dp28),
    .dm_win28_in(dm28), .dp_win31_in(dp31), .dm_win31_in(dm31), .dp_at_vbus_in(dpv), .dm_at_vbus_in(dmv));
  // Inputs change and outputs are read 1 ns after each edge
  task automatic step(int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // Expected pin levels: found, switch, switch pin, permit, expired, two constant drives
  function automatic logic [6:0] model(int k, int b, int x);
    logic f;
    logic c;
    f = (k >= 2 && k <= 5 && x == 0);
    c = ((k == 1 || k == 2) && b == 1 && x == 0);
    model = {f, c, c, x == 0, x == 1, 2'b00};
  endfunction : model
  task automatic wait_class();
    for (n = 0; n < TMO && cls === 3'h0; n++) step(1);
  endtask : wait_class
  task automatic attach(int k, int b);
    vbus = 1'b0;
    step(2);
    chk({1'b0, outs} | {5'h0, cls}, 8'h00);
    kind = 3'(k);
    bat = b[0];
    vbus = 1'b1;
    step(1);
    chk({5'h0, dcd_en, dp_src, dm_src}, 8'h04);
    wait_class();
    chk({5'h0, cls}, 8'(k));
    chk({1'b0, outs}, {1'b0, model(k, b, 0)});
    // Switch follows the battery input live
    bat = ~bat;
    step(2);
    chk({1'b0, outs}, {1'b0, model(k, 1 - b, 0)});
  endtask : attach
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    n = $urandom(32'h1D4D);
    step(3);
    srst = 1'b0;
    for (int b = 0; b < 2; b++) begin
      for (int k = 1; k < 8; k++) attach(k, b);
    end
    for (int r = 0; r < 6; r++) attach(1 + $urandom % 7, $urandom % 2);
    attach(2, 1);
    for (n = 0; n < 2 * DBT && expired !== 1'b1; n++) step(1);
    chk({7'h0, n + 4 >= DBT && n <= DBT * 3 / 2}, 8'h01);
    chk({1'b0, outs}, {1'b0, model(2, 0, 1)});
    // The system reports a good battery again
    bat = 1'b1;
    step(1);
    chk({6'h0, dcd_en, expired}, 8'h02);
    wait_class();
    chk({1'b0, outs}, {1'b0, model(2, 1, 0)});
    chk({5'h0, cls}, 8'h02);
    vbus = 1'b0;
    step(1);
    chk({1'b0, outs}, 8'h00);
    report_and_stop();
  end
endmodule : testbench
bind ucd_seq ucd_seq_assertions #(.DCD_TIMEOUT_CYC(DCD_TIMEOUT_CYC), .DBT_CYC(DBT_CYC)) i_ucd_seq_assertions (
  .clk_sys(clk_sys), .srst(srst), .vbus_valid_in(vbus_valid_in), .battery_ok_in(battery_ok_in),
  .contact_in(contact_in), .dminus_above_vdat_in(dminus_above_vdat_in), .dcd_src_en(dcd_src_en),
  .dplus_src_en(dplus_src_en), .dminus_source_voltage_en(dminus_source_voltage_en),
  .data_switch_close(data_switch_close), .switch_state_out_o(switch_state_out_o),
  .switch_state_out_oe(switch_state_out_oe), .charge_permit_n_o(charge_permit_n_o),
  .charge_permit_n_oe(charge_permit_n_oe), .charger_found_out(charger_found_out),
  .detected_class(detected_class), .dead_battery_expired(dead_battery_expired));
